// ==== logic/adc_rdy_pkg.sv ====
// Shared constants for the conversion-ready, alignment and correction block
package adc_rdy_pkg;
   localparam int          CLOCK_HZ          = 25000000;
   localparam int          GAP_NS            = 500;
   // Ready gap before a fresh result, rounded down, at least one cycle
   localparam int          GAP_CYCLES_RAW    = (GAP_NS * (CLOCK_HZ / 1000000)) / 1000;
   localparam int          GAP_CYCLES        = (GAP_CYCLES_RAW < 1) ? 1 : GAP_CYCLES_RAW;
   localparam int          SETTLE_RESULTS    = 4;
   localparam int          SYNC_TOL          = 1;
   localparam logic [23:0] OFFSET_RESET      = 24'h000000;
   localparam logic [23:0] GAIN_RESET        = 24'hC00000;
   localparam logic [23:0] GAIN_UNITY        = 24'h800000;
   localparam int          GAIN_FRAC_BITS    = 23;
   localparam logic [23:0] CODE_NEG_FULL     = 24'h800000;
   localparam logic [23:0] CODE_POS_FULL     = 24'h7FFFFF;
   localparam logic [3:0]  RATE_FASTEST      = 4'hF;
   localparam int          CHAN_COUNT        = 16;

   typedef enum logic [1:0] {
      MODE_SINGLE,
      MODE_CONT_SINGLE,
      MODE_CONT_FILTERED
   } conv_mode_t;
endpackage : adc_rdy_pkg

// ==== logic/adc_sync_monitor.sv ====
// Alignment-pulse timing monitor that restarts conversion on drift
`timescale 1ns/1ps
`default_nettype none
module adc_sync_monitor #(
   parameter int CNT_W = 20
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic sync_enable,
   input  wire logic adc_tick,
   input  wire logic sync_in,
   input  wire logic ready_fall,
   output logic      restart_pulse,
   output logic      reference_valid
);
   initial begin
      if (CNT_W < 2) $error("CNT_W too small");
   end

   logic             sync_prev_q, sync_prev_d;
   logic             armed_q, armed_d;
   logic             have_ref_q, have_ref_d;
   logic             counting_q, counting_d;
   logic [CNT_W-1:0] count_q, count_d;
   logic [CNT_W-1:0] ref_q, ref_d;
   logic             restart_q, restart_d;
   logic             sync_rise;
   logic [CNT_W-1:0] diff;

   assign sync_rise = sync_in & ~sync_prev_q;
   assign diff      = (count_q > ref_q) ? (count_q - ref_q) : (ref_q - count_q);

   always_comb begin
      sync_prev_d = sync_in;
      armed_d     = armed_q;
      have_ref_d  = have_ref_q;
      counting_d  = counting_q;
      count_d     = count_q;
      ref_d       = ref_q;
      restart_d   = 1'b0;
      if (!sync_enable) begin
         armed_d    = 1'b0;
         have_ref_d = 1'b0;
         counting_d = 1'b0;
      end else begin
         // Count ADC clock ticks from the latest ready fall
         if (ready_fall) begin
            armed_d    = 1'b1;
            counting_d = 1'b1;
            count_d    = '0;
         end else if (counting_q && adc_tick && count_q != '1) begin
            count_d = count_q + 1'b1;
         end
         if (sync_rise && armed_q && counting_q && !ready_fall) begin
            counting_d = 1'b0;
            if (!have_ref_q) begin
               ref_d      = count_q;
               have_ref_d = 1'b1;
            end else if (diff > CNT_W'(adc_rdy_pkg::SYNC_TOL)) begin
               restart_d  = 1'b1;
               armed_d    = 1'b0;
               counting_d = 1'b0;
            end
            // Within tolerance the count stops and no restart is raised
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync_prev_q <= 1'b0;
         armed_q     <= 1'b0;
         have_ref_q  <= 1'b0;
         counting_q  <= 1'b0;
         count_q     <= '0;
         ref_q       <= '0;
         restart_q   <= 1'b0;
      end else begin
         sync_prev_q <= sync_prev_d;
         armed_q     <= armed_d;
         have_ref_q  <= have_ref_d;
         counting_q  <= counting_d;
         count_q     <= count_d;
         ref_q       <= ref_d;
         restart_q   <= restart_d;
      end
   end

   assign restart_pulse   = restart_q;
   assign reference_valid = have_ref_q;

   AST_NO_REF_BEFORE_ARM: assert property (@(posedge clock) disable iff (sys_rst)
      (!armed_q && !have_ref_q) |=> !have_ref_q)
      else $error("reference taken before ready fall");
   AST_RESTART_ON_DRIFT: assert property (@(posedge clock) disable iff (sys_rst)
      (sync_enable && sync_rise && armed_q && counting_q && !ready_fall && have_ref_q
       && diff > 1) |=> restart_q)
      else $error("drift did not restart");
   AST_NO_RESTART_IN_TOL: assert property (@(posedge clock) disable iff (sys_rst)
      (sync_rise && have_ref_q && diff <= 1) |=> !restart_q)
      else $error("restart within tolerance");
   COV_RESTART: cover property (@(posedge clock) disable iff (sys_rst) restart_q);
endmodule // adc_sync_monitor
`default_nettype wire

// ==== logic/adc_correction.sv ====
// Per-channel offset and gain correction with indirect coefficient access
`timescale 1ns/1ps
`default_nettype none
module adc_correction #(
   parameter int CHANNELS = 16
) (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   input  wire logic [3:0]  input_channel_select,
   input  wire logic [3:0]  coefficient_channel_pointer,
   input  wire logic        offset_write,
   input  wire logic        gain_write,
   input  wire logic [23:0] coef_write_data,
   output logic [23:0]      indexed_offset_coefficient,
   output logic [23:0]      indexed_gain_coefficient,
   input  wire logic        gain_correction_disable,
   input  wire logic        offset_correction_disable,
   input  wire logic        correction_bypass,
   input  wire logic [23:0] raw_code,
   output logic [23:0]      corrected_code,
   output logic             active_channel_hit
);
   initial begin
      if (CHANNELS < 1 || CHANNELS > 16) $error("CHANNELS out of range");
   end

   logic [23:0] offset_q [CHANNELS];
   logic [23:0] gain_q   [CHANNELS];
   logic [23:0] offset_d [CHANNELS];
   logic [23:0] gain_d   [CHANNELS];

   // Each channel owns its own pair; the pointer picks the one exposed
   for (genvar i = 0; i < CHANNELS; i++) begin : g_coef
      always_comb begin
         offset_d[i] = offset_q[i];
         gain_d[i]   = gain_q[i];
         if (offset_write && coefficient_channel_pointer == 4'(i)) offset_d[i] = coef_write_data;
         if (gain_write && coefficient_channel_pointer == 4'(i)) gain_d[i] = coef_write_data;
      end
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            offset_q[i] <= adc_rdy_pkg::OFFSET_RESET;
            gain_q[i]   <= adc_rdy_pkg::GAIN_RESET;
         end else begin
            offset_q[i] <= offset_d[i];
            gain_q[i]   <= gain_d[i];
         end
      end
   end

   function automatic logic in_range(input logic [3:0] ch);
      in_range = 32'(ch) < CHANNELS;
   endfunction

   assign indexed_offset_coefficient = in_range(coefficient_channel_pointer)
                                       ? offset_q[coefficient_channel_pointer] : 24'h000000;
   assign indexed_gain_coefficient   = in_range(coefficient_channel_pointer)
                                       ? gain_q[coefficient_channel_pointer] : 24'h000000;
   assign active_channel_hit = (offset_write | gain_write)
                               && coefficient_channel_pointer == input_channel_select;

   logic signed [24:0] off_ext;
   logic        [23:0] gain_eff;
   logic signed [49:0] product;
   logic signed [49:0] scaled;
   logic signed [49:0] sum;

   always_comb begin
      gain_eff = adc_rdy_pkg::GAIN_UNITY;
      off_ext  = 25'sd0;
      if (in_range(input_channel_select) && !correction_bypass) begin
         // Disabled correction behaves as unity gain and zero offset
         gain_eff = gain_correction_disable ? adc_rdy_pkg::GAIN_UNITY
                                            : gain_q[input_channel_select];
         off_ext  = offset_correction_disable ? 25'sd0
                    : 25'($signed(offset_q[input_channel_select]));
      end
      // Offset in offset-scale units; gain with 2^23 as one
      product = 50'($signed(raw_code) - off_ext) * $signed({26'h0000000, gain_eff});
      scaled  = product >>> adc_rdy_pkg::GAIN_FRAC_BITS;
      sum     = scaled;
   end

   // Saturate to the two's complement 24-bit code range
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         corrected_code <= 24'h000000;
      end else if (correction_bypass) begin
         corrected_code <= raw_code;
      end else if (sum > 50'sd8388607) begin
         corrected_code <= adc_rdy_pkg::CODE_POS_FULL;
      end else if (sum < -50'sd8388608) begin
         corrected_code <= adc_rdy_pkg::CODE_NEG_FULL;
      end else begin
         corrected_code <= sum[23:0];
      end
   end
endmodule // adc_correction
`default_nettype wire

// ==== logic/adc_ready_sync_calibration.sv ====
// Conversion-ready output, result register, alignment and correction top
`timescale 1ns/1ps
`default_nettype none
module adc_ready_sync_calibration #(
   parameter int CHANNELS = adc_rdy_pkg::CHAN_COUNT,
   parameter int SYNC_W   = 20
) (
   input  wire logic        clock,
   input  wire logic        sys_rst,
   // ---------------------------------------------------------------
   // Converter side
   // ---------------------------------------------------------------
   input  wire logic        result_strobe,
   input  wire logic [23:0] raw_code,
   input  wire logic [1:0]  conversion_mode,
   input  wire logic [3:0]  conversion_rate,
   input  wire logic        conversion_start,
   input  wire logic        adc_tick,
   output logic             conversion_abort,
   output logic             filter_clear,
   output logic             conversions_halted,
   // ---------------------------------------------------------------
   // Control and host access
   // ---------------------------------------------------------------
   input  wire logic        alignment_mode_enable,
   input  wire logic        external_clock_select,
   input  wire logic        sync_in,
   input  wire logic [3:0]  input_channel_select,
   input  wire logic        gain_correction_disable,
   input  wire logic        offset_correction_disable,
   input  wire logic [3:0]  coefficient_channel_pointer,
   input  wire logic        offset_write,
   input  wire logic        gain_write,
   input  wire logic [23:0] coef_write_data,
   output logic [23:0]      indexed_offset_coefficient,
   output logic [23:0]      indexed_gain_coefficient,
   input  wire logic        result_read,
   output logic [23:0]      conversion_result_reg,
   output logic             ready_n,
   output logic             adc_clock_external,
   output logic             reference_valid
);
   initial begin
      if (SYNC_W < 2) $error("SYNC_W too small");
   end

   typedef enum logic [1:0] {
      RDY_IDLE,
      RDY_GAP,
      RDY_WAIT_CODE
   } rdy_state_t;

   localparam int GAP_W = $clog2(adc_rdy_pkg::GAP_CYCLES + 1);

   logic        filtered_mode;
   logic        continuous;
   logic        bypass;
   logic        live_hit;
   logic        restart;
   logic [23:0] corrected;

   assign filtered_mode = conversion_mode == 2'(adc_rdy_pkg::MODE_CONT_FILTERED);
   assign continuous    = filtered_mode
                          || conversion_mode == 2'(adc_rdy_pkg::MODE_CONT_SINGLE);
   assign bypass        = filtered_mode && conversion_rate == adc_rdy_pkg::RATE_FASTEST;
   assign adc_clock_external = external_clock_select;

   // ---------------------------------------------------------------
   // Correction path
   // ---------------------------------------------------------------
   adc_correction #(
      .CHANNELS (CHANNELS)
   ) u_corr (
      .clock                       (clock),
      .sys_rst                     (sys_rst),
      .input_channel_select        (input_channel_select),
      .coefficient_channel_pointer (coefficient_channel_pointer),
      .offset_write                (offset_write),
      .gain_write                  (gain_write),
      .coef_write_data             (coef_write_data),
      .indexed_offset_coefficient  (indexed_offset_coefficient),
      .indexed_gain_coefficient    (indexed_gain_coefficient),
      .gain_correction_disable     (gain_correction_disable),
      .offset_correction_disable   (offset_correction_disable),
      .correction_bypass           (bypass),
      .raw_code                    (raw_code),
      .corrected_code              (corrected),
      .active_channel_hit          (live_hit)
   );

   // ---------------------------------------------------------------
   // Ready output sequencing
   // ---------------------------------------------------------------
   rdy_state_t       state_q, state_d;
   logic             ready_n_q, ready_n_d;
   logic [23:0]      result_q, result_d;
   logic [GAP_W-1:0] gap_q, gap_d;
   logic [2:0]       settle_q, settle_d;
   logic             halted_q, halted_d;
   logic [23:0]      pending_q, pending_d;
   logic             ready_fall;
   logic             accept;

   // Corrected code is registered one cycle after the strobe, so the state
   // machine waits one cycle for it before publishing.
   assign accept = result_strobe && !halted_q && !restart;

   always_comb begin
      state_d   = state_q;
      ready_n_d = ready_n_q;
      result_d  = result_q;
      gap_d     = gap_q;
      settle_d  = settle_q;
      halted_d  = halted_q;
      pending_d = pending_q;
      if (conversion_start) begin
         halted_d = 1'b0;
         settle_d = '0;
      end
      if (live_hit && continuous) begin
         halted_d = 1'b1;
      end
      if (restart) begin
         settle_d = '0;
      end
      if (result_read && !ready_n_q) begin
         ready_n_d = 1'b1;
      end
      case (state_q)
         RDY_IDLE: begin
            if (accept) begin
               if (filtered_mode && 32'(settle_q) < adc_rdy_pkg::SETTLE_RESULTS) begin
                  settle_d = settle_q + 3'h1;
               end else if (!ready_n_q && continuous) begin
                  ready_n_d = 1'b1;
                  gap_d     = GAP_W'(adc_rdy_pkg::GAP_CYCLES);
                  state_d   = RDY_GAP;
               end else begin
                  state_d = RDY_WAIT_CODE;
               end
            end
         end
         RDY_GAP: begin
            ready_n_d = 1'b1;
            // The raw code stands only with its strobe, so the fresh word is
            // parked here while the old result stays readable
            if (gap_q == GAP_W'(adc_rdy_pkg::GAP_CYCLES)) begin
               pending_d = corrected;
            end
            if (gap_q <= GAP_W'(1)) begin
               result_d  = pending_d;
               ready_n_d = 1'b0;
               state_d   = RDY_IDLE;
            end else begin
               gap_d = gap_q - GAP_W'(1);
            end
         end
         RDY_WAIT_CODE: begin
            result_d  = corrected;
            ready_n_d = 1'b0;
            state_d   = RDY_IDLE;
         end
         default: state_d = RDY_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_q   <= RDY_IDLE;
         ready_n_q <= 1'b1;
         result_q  <= 24'h000000;
         gap_q     <= '0;
         settle_q  <= '0;
         halted_q  <= 1'b0;
         pending_q <= 24'h000000;
      end else begin
         state_q   <= state_d;
         ready_n_q <= ready_n_d;
         result_q  <= result_d;
         gap_q     <= gap_d;
         settle_q  <= settle_d;
         halted_q  <= halted_d;
         pending_q <= pending_d;
      end
   end

   assign ready_fall = ready_n_q && !ready_n_d;

   // ---------------------------------------------------------------
   // Alignment monitor
   // ---------------------------------------------------------------
   adc_sync_monitor #(
      .CNT_W (SYNC_W)
   ) u_sync (
      .clock           (clock),
      .sys_rst         (sys_rst),
      .sync_enable     (alignment_mode_enable),
      .adc_tick        (adc_tick),
      .sync_in         (sync_in),
      .ready_fall      (ready_fall),
      .restart_pulse   (restart),
      .reference_valid (reference_valid)
   );

   assign conversion_abort      = restart || live_hit;
   assign filter_clear          = restart;
   assign conversions_halted    = halted_q;
   assign conversion_result_reg = result_q;
   assign ready_n               = ready_n_q;

   // ---------------------------------------------------------------
   // Assertion helpers
   // ---------------------------------------------------------------
   // The gap length is kept in a counter, since a long repetition would
   // make the property tools unroll every cycle of it
   localparam int GAP_LEN = adc_rdy_pkg::GAP_CYCLES;

   logic [GAP_W-1:0] gap_run_q, gap_run_d;

   always_comb begin
      gap_run_d = '0;
      if (state_q == RDY_GAP && gap_run_q != '1) begin
         gap_run_d = gap_run_q + GAP_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gap_run_q <= '0;
      end else begin
         gap_run_q <= gap_run_d;
      end
   end

   AST_READ_RAISES: assert property (@(posedge clock) disable iff (sys_rst)
      (result_read && !ready_n_q && state_q == RDY_IDLE && !accept) |=> ready_n_q)
      else $error("read did not raise ready");
   AST_FALL_WITH_RESULT: assert property (@(posedge clock) disable iff (sys_rst)
      (state_q == RDY_WAIT_CODE) |=> (!ready_n_q && result_q == $past(corrected)))
      else $error("result not published");
   AST_GAP_LEN: assert property (@(posedge clock) disable iff (sys_rst)
      $rose(state_q == RDY_GAP) |-> ##GAP_LEN (!ready_n_q && state_q == RDY_IDLE))
      else $error("gap length wrong");
   AST_GAP_HOLDS: assert property (@(posedge clock) disable iff (sys_rst)
      (state_q == RDY_GAP)
      |-> (ready_n_q && $stable(result_q) && 32'(gap_run_q) < GAP_LEN))
      else $error("gap too long or not high");
   AST_SETTLE_HIGH: assert property (@(posedge clock) disable iff (sys_rst)
      (accept && filtered_mode && settle_q < 3'h4 && state_q == RDY_IDLE)
      |=> state_q == RDY_IDLE)
      else $error("ready during settling");
   AST_RESET_HIGH: assert property (@(posedge clock)
      $fell(sys_rst) |-> ready_n_q)
      else $error("ready low after reset");
   AST_HALT_ON_HIT: assert property (@(posedge clock) disable iff (sys_rst)
      (live_hit && continuous && !conversion_start) |=> halted_q)
      else $error("no halt on live write");
   AST_START_RELEASES: assert property (@(posedge clock) disable iff (sys_rst)
      (conversion_start && !(live_hit && continuous)) |=> !halted_q)
      else $error("start did not release halt");
   COV_HALTED: cover property (@(posedge clock) disable iff (sys_rst) $rose(halted_q));
   AST_BYPASS_FAST: assert property (@(posedge clock) disable iff (sys_rst)
      bypass |=> u_corr.corrected_code == $past(raw_code))
      else $error("correction not bypassed");
   COV_GAP: cover property (@(posedge clock) disable iff (sys_rst) state_q == RDY_GAP);
   COV_READ: cover property (@(posedge clock) disable iff (sys_rst) $rose(ready_n_q));
   COV_SETTLED: cover property (@(posedge clock) disable iff (sys_rst)
      filtered_mode && $fell(ready_n_q));
endmodule // adc_ready_sync_calibration
`default_nettype wire

// ==== test/host_sync_model.sv ====
// Host-side model that raises alignment pulses on request
`timescale 1ns/1ps
`default_nettype none
module host_sync_model #(
   parameter int HOLD_CYC = 9
) (
   input  wire logic clock,
   input  wire logic fire,
   output logic      sync_in
);
   initial sync_in = 1'b0;
   // Nine cycles of 40 ns keep both the pulse and the gap above 300 ns
   always @(posedge clock) begin
      if (fire) begin
         @(negedge clock);
         sync_in = 1'b1;
         repeat (HOLD_CYC) @(negedge clock);
         sync_in = 1'b0;
         repeat (HOLD_CYC) @(negedge clock);
      end
   end
endmodule // host_sync_model
`default_nettype wire

// ==== test/adc_ready_sync_calibration_test.sv ====
// Self-checking bench for the conversion-ready, alignment and correction block
`timescale 1ns/1ps
`default_nettype none
module adc_ready_sync_calibration_test;
   localparam int GAP = adc_rdy_pkg::GAP_CYCLES;
   logic        clock, sys_rst, result_strobe, conversion_start, adc_tick, fire;
   logic        alignment_mode_enable, external_clock_select, result_read;
   logic        gain_correction_disable, offset_correction_disable, offset_write, gain_write;
   logic [23:0] raw_code, coef_write_data;
   logic [1:0]  conversion_mode;
   logic [3:0]  conversion_rate, input_channel_select, coefficient_channel_pointer;
   wire logic   sync_in, conversion_abort, filter_clear, conversions_halted;
   wire logic   ready_n, adc_clock_external, reference_valid;
   wire logic [23:0] indexed_offset_coefficient, indexed_gain_coefficient, conversion_result_reg;
   int          mismatches, comparisons, n;
   logic [1:0]  seen;

   adc_ready_sync_calibration #(.SYNC_W(8)) u_dut (
      .clock, .sys_rst, .result_strobe, .raw_code, .conversion_mode, .conversion_rate,
      .conversion_start, .adc_tick, .conversion_abort, .filter_clear, .conversions_halted,
      .alignment_mode_enable, .external_clock_select, .sync_in, .input_channel_select,
      .gain_correction_disable, .offset_correction_disable, .coefficient_channel_pointer,
      .offset_write, .gain_write, .coef_write_data, .indexed_offset_coefficient,
      .indexed_gain_coefficient, .result_read, .conversion_result_reg, .ready_n,
      .adc_clock_external, .reference_valid);

   host_sync_model u_host (.clock, .fire, .sync_in);

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         mismatches++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask

   task automatic strobe(input logic [23:0] code);
      raw_code = code;
      result_strobe = 1'b1;
      cyc(1);
      result_strobe = 1'b0;
      raw_code = 24'h000000;
   endtask

   // Bounded: a ready output that never falls ends the run
   task automatic wait_low(input int lim);
      n = 0;
      while (ready_n !== 1'b0) begin
         cyc(1);
         n++;
         if (n > lim) begin
            chk(1'b0, "ready never fell");
            print_verdict();
         end
      end
   endtask

   task automatic rd;
      result_read = 1'b1;
      cyc(1);
      result_read = 1'b0;
      chk(ready_n === 1'b1, "ready not released after read");
   endtask

   task automatic conv(input logic [23:0] code, input logic [23:0] exp);
      strobe(code);
      wait_low(8);
      chk(conversion_result_reg === exp, "result code");
      rd();
   endtask

   task automatic align(input int d);
      strobe(24'h000100);
      wait_low(8);
      cyc(d);
      fire = 1'b1;
      cyc(1);
      fire = 1'b0;
      seen = 2'b00;
      repeat (30) begin
         cyc(1);
         seen = seen | {filter_clear === 1'b1, conversion_abort === 1'b1};
      end
      rd();
   endtask

   task automatic t_reset;
      chk(ready_n === 1'b1, "ready low after reset");
      coefficient_channel_pointer = 4'h3;
      #1;
      chk(indexed_offset_coefficient === 24'h000000, "offset default");
      chk(indexed_gain_coefficient === 24'hC00000, "gain default");
      $display("test reset done");
   endtask

   task automatic t_align;
      alignment_mode_enable = 1'b1;
      external_clock_select = 1'b1;
      conversion_mode = 2'h1;
      #1;
      chk(adc_clock_external === 1'b1, "external clock select");
      fire = 1'b1;
      cyc(1);
      fire = 1'b0;
      cyc(30);
      chk(reference_valid === 1'b0, "early pulse taken");
      align(20);
      chk(reference_valid === 1'b1, "no reference");
      align(21);
      chk(seen === 2'b00, "restart within tolerance");
      align(24);
      chk(seen === 2'b11, "no restart on drift");
      alignment_mode_enable = 1'b0;
      external_clock_select = 1'b0;
      $display("test alignment done");
   endtask

   task automatic t_corr;
      conversion_mode = 2'h0;
      input_channel_select = 4'h1;
      coefficient_channel_pointer = 4'h2;
      coef_write_data = 24'h000010;
      offset_write = 1'b1;
      cyc(1);
      offset_write = 1'b0;
      coef_write_data = 24'h800000;
      gain_write = 1'b1;
      cyc(1);
      gain_write = 1'b0;
      #1;
      chk(indexed_offset_coefficient === 24'h000010, "offset window");
      chk(indexed_gain_coefficient === 24'h800000, "gain window");
      conv(24'h100000, 24'h180000);
      conv(24'hF00000, 24'hE80000);
      input_channel_select = 4'h2;
      conv(24'h000100, 24'h0000F0);
      offset_correction_disable = 1'b1;
      conv(24'h000100, 24'h000100);
      offset_correction_disable = 1'b0;
      input_channel_select = 4'h1;
      gain_correction_disable = 1'b1;
      conv(24'h100000, 24'h100000);
      gain_correction_disable = 1'b0;
      $display("test correction done");
   endtask

   task automatic t_gap;
      conversion_mode = 2'h1;
      strobe(24'h000200);
      wait_low(8);
      cyc(GAP + 3);
      strobe(24'h000400);
      cyc(1);
      chk(ready_n === 1'b1, "no gap before fresh result");
      cyc(GAP - 3);
      chk(conversion_result_reg === 24'h000300, "old result lost early");
      wait_low(10);
      chk(conversion_result_reg === 24'h000600, "fresh result");
      rd();
      $display("test gap done");
   endtask

   task automatic t_filt;
      conversion_mode = 2'h2;
      conversion_rate = 4'hF;
      conversion_start = 1'b1;
      cyc(1);
      conversion_start = 1'b0;
      repeat (4) begin
         strobe(24'h000200);
         cyc(GAP + 3);
         chk(ready_n === 1'b1, "ready during settling");
      end
      conv(24'h000200, 24'h000200);
      conversion_rate = 4'h0;
      $display("test filtered done");
   endtask

   task automatic t_live;
      conversion_mode = 2'h1;
      coefficient_channel_pointer = 4'h1;
      coef_write_data = 24'hC00000;
      gain_write = 1'b1;
      #1;
      chk(conversion_abort === 1'b1, "no abort on live write");
      cyc(1);
      gain_write = 1'b0;
      cyc(1);
      chk(conversions_halted === 1'b1, "not halted");
      strobe(24'h000200);
      cyc(6);
      chk(ready_n === 1'b1, "result while halted");
      conversion_start = 1'b1;
      cyc(1);
      conversion_start = 1'b0;
      chk(conversions_halted === 1'b0, "halt not released");
      $display("test live write done");
   endtask

   initial begin
      {result_strobe, conversion_start, fire, result_read, offset_write, gain_write} = '0;
      {alignment_mode_enable, external_clock_select} = '0;
      {gain_correction_disable, offset_correction_disable} = '0;
      raw_code = 24'h000000;
      coef_write_data = 24'h000000;
      conversion_mode = 2'h0;
      conversion_rate = 4'h0;
      input_channel_select = 4'h1;
      coefficient_channel_pointer = 4'h0;
      adc_tick = 1'b1;
      mismatches = 0;
      comparisons = 0;
      sys_rst = 1'b1;
      cyc(3);
      sys_rst = 1'b0;
      cyc(1);
      t_reset();
      t_align();
      t_corr();
      t_gap();
      t_filt();
      t_live();
      print_verdict();
   end
endmodule // adc_ready_sync_calibration_test
`default_nettype wire
